// >>> rtl/hsc_pkg.sv
package hsc_pkg;
  // clock and shared serial clock timing
  localparam int          CLK_PERIOD_NS = 20;
  localparam int          SCL_HALF_NS   = 5000;
  localparam int          SCL_HALF_CYC  = (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // geometry
  localparam int          NUM_PORTS     = 4;
  localparam int          ADDR_W        = 8;

  // register byte addresses
  localparam logic [7:0]  CTRL_ADDR     = 8'h00;
  localparam logic [7:0]  RMBL_ADDR     = 8'h04;
  localparam logic [7:0]  USED_ADDR     = 8'h08;
  localparam logic [7:0]  STAT_ADDR     = 8'h0C;

  // control register fields
  localparam int          CTRL_LOADED_BIT = 0;
  localparam int          CTRL_LPDIS_BIT  = 1;

  // status register fields
  localparam int          STAT_RMBL_LSB   = 0;
  localparam int          STAT_USED_LSB   = 4;
  localparam int          STAT_CAPT_BIT   = 8;
  localparam int          STAT_SCL_BIT    = 9;
  localparam int          STAT_SDA_BIT    = 10;
  localparam int          STAT_MODE_BIT   = 11;
  localparam int          STAT_INIT_BIT   = 12;
  localparam int          STAT_ACPT_BIT   = 13;

  // reset values
  localparam logic [1:0]  CTRL_RST        = 2'h0;
  localparam logic [3:0]  OVR_RST         = 4'h0;
  localparam logic [2:0]  RMBL_LOW_STRAP  = 3'h0;
endpackage

// >>> rtl/hsc_strap_if.sv
`timescale 1ns/1ps
interface hsc_strap_if;
  logic       captured;
  logic       rmbl3;
  logic [3:0] used;
  logic       scl_strap;
  logic       sda_strap;

  modport sampler (output captured, output rmbl3, output used, output scl_strap, output sda_strap);
  modport core    (input  captured, input  rmbl3, input  used, input  scl_strap, input  sda_strap);
endinterface

// >>> rtl/hsc_strap_sampler.sv
`timescale 1ns/1ps
module hsc_strap_sampler (
  input  wire logic   ref_clk,
  input  wire logic   srst,
  input  wire logic   port3_amber_removable_strap,
  input  wire logic   port0_green_used_strap,
  input  wire logic   port1_green_used_strap,
  input  wire logic   port2_green_used_strap,
  input  wire logic   port3_green_used_strap,
  input  wire logic   shared_serial_clock_pin,
  input  wire logic   shared_serial_data_pin,
  hsc_strap_if.sampler sif
);
  import hsc_pkg::*;

  logic       captured_q;
  logic       rmbl3_q;
  logic [3:0] used_q;
  logic       scl_q;
  logic       sda_q;
  wire        capture_now = !captured_q;

  // first cycle after reset release catches the port and serial pin straps, then holds
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      captured_q <= 1'b0;
      rmbl3_q    <= 1'b0;
      used_q     <= 4'h0;
      scl_q      <= 1'b0;
      sda_q      <= 1'b0;
    end else if (capture_now) begin
      captured_q <= 1'b1;
      rmbl3_q    <= port3_amber_removable_strap;
      used_q     <= {port3_green_used_strap, port2_green_used_strap,
                     port1_green_used_strap, port0_green_used_strap};
      scl_q      <= shared_serial_clock_pin;
      sda_q      <= shared_serial_data_pin;
    end
  end

  // the held values are what the rest of the block sees
  assign sif.captured  = captured_q;
  assign sif.rmbl3     = rmbl3_q;
  assign sif.used      = used_q;
  assign sif.scl_strap = scl_q;
  assign sif.sda_strap = sda_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  property p_rmbl_capture;
    $rose(captured_q) |-> rmbl3_q == $past(port3_amber_removable_strap);
  endproperty
  a_rmbl_capture: assert property (p_rmbl_capture) else $error("removable strap not captured");

  property p_used_capture;
    $rose(captured_q) |-> used_q == $past({port3_green_used_strap, port2_green_used_strap,
                                            port1_green_used_strap, port0_green_used_strap});
  endproperty
  a_used_capture: assert property (p_used_capture) else $error("port used straps not captured");

  property p_scl_capture;
    $rose(captured_q) |-> scl_q == $past(shared_serial_clock_pin) && sda_q == $past(shared_serial_data_pin);
  endproperty
  a_scl_capture: assert property (p_scl_capture) else $error("serial pin straps not captured");

  property p_hold;
    captured_q |=> captured_q && $stable(rmbl3_q) && $stable(used_q) && $stable(scl_q) && $stable(sda_q);
  endproperty
  a_hold: assert property (p_hold) else $error("strap value changed after capture");
endmodule

// >>> rtl/hsc_strap_config_sampler.sv
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps
module hsc_strap_config_sampler #(
  parameter int SCL_HALF = hsc_pkg::SCL_HALF_CYC,
  parameter logic [2:0] RMBL_LOW = hsc_pkg::RMBL_LOW_STRAP
) (
  input  wire logic                      ref_clk,
  input  wire logic                      srst,
  // apb slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [hsc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // strap pins
  input  wire logic                      port3_amber_removable_strap,
  input  wire logic                      port0_green_used_strap,
  input  wire logic                      port1_green_used_strap,
  input  wire logic                      port2_green_used_strap,
  input  wire logic                      port3_green_used_strap,
  input  wire logic                      host_interface_mode_select,
  // shared serial clock pin, open drain
  input  wire logic                      shared_serial_clock_pin,
  output logic                           scl_out,
  output logic                           scl_oe,
  input  wire logic                      shared_serial_data_pin,
  // results
  output logic                           smbus_clk_level,
  output logic      [3:0]                port_removable,
  output logic      [3:0]                port_used,
  output logic                           u1u2_initiate_en,
  output logic                           u1u2_accept_en
);
  import hsc_pkg::*;

  localparam int CNT_W = $clog2(SCL_HALF + 1);

  hsc_strap_if sif ();

  hsc_strap_sampler u_sampler (
    .ref_clk                     (ref_clk),
    .srst                        (srst),
    .port3_amber_removable_strap (port3_amber_removable_strap),
    .port0_green_used_strap      (port0_green_used_strap),
    .port1_green_used_strap      (port1_green_used_strap),
    .port2_green_used_strap      (port2_green_used_strap),
    .port3_green_used_strap      (port3_green_used_strap),
    .shared_serial_clock_pin     (shared_serial_clock_pin),
    .shared_serial_data_pin      (shared_serial_data_pin),
    .sif                         (sif.sampler)
  );

  // register state
  logic [1:0]       ctrl_q;
  logic [3:0]       rmbl_ovr_q;
  logic             rmbl_set_q;
  logic [3:0]       used_ovr_q;
  logic             used_set_q;
  logic [31:0]      prdata_q;
  logic [3:0]       removable_q;
  logic [3:0]       used_q;
  logic             init_q;
  logic             acpt_q;
  logic [CNT_W-1:0] scl_cnt_q;
  logic             scl_level_q;
  logic             smb_clk_q;

  // apb decode
  wire setup_ph  = psel && !penable;
  wire access_ph = psel && penable;
  wire hit_ctrl  = (paddr == CTRL_ADDR);
  wire hit_rmbl  = (paddr == RMBL_ADDR);
  wire hit_used  = (paddr == USED_ADDR);
  wire hit_stat  = (paddr == STAT_ADDR);
  wire mapped    = hit_ctrl || hit_rmbl || hit_used || hit_stat;
  wire wr_ok     = access_ph && pwrite && mapped;
  wire wr_ctrl   = wr_ok && hit_ctrl;
  wire wr_rmbl   = wr_ok && hit_rmbl;
  wire wr_used   = wr_ok && hit_used;

  // configuration contents loaded stand in for straps
  wire cfg_loaded = ctrl_q[CTRL_LOADED_BIT];
  wire lp_disable = ctrl_q[CTRL_LPDIS_BIT];

  // effective port options
  wire [3:0] rmbl_strap = {sif.rmbl3, RMBL_LOW};
  wire [3:0] rmbl_eff   = (cfg_loaded || rmbl_set_q) ? rmbl_ovr_q : rmbl_strap;
  wire [3:0] used_eff   = (cfg_loaded || used_set_q) ? used_ovr_q : sif.used;

  // low-power policy, loaded bit first, then data strap, then clock strap
  wire init_eff = cfg_loaded    ? !lp_disable :
                  sif.sda_strap ? 1'b0 :
                  !sif.scl_strap;
  wire acpt_eff = cfg_loaded    ? !lp_disable :
                  !sif.sda_strap;

  // status word
  logic [31:0] stat_word;
  always_comb begin
    stat_word                                 = 32'h0000_0000;
    stat_word[STAT_RMBL_LSB +: NUM_PORTS]     = rmbl_strap;
    stat_word[STAT_USED_LSB +: NUM_PORTS]     = sif.used;
    stat_word[STAT_CAPT_BIT]                  = sif.captured;
    stat_word[STAT_SCL_BIT]                   = sif.scl_strap;
    stat_word[STAT_SDA_BIT]                   = sif.sda_strap;
    stat_word[STAT_MODE_BIT]                  = host_interface_mode_select;
    stat_word[STAT_INIT_BIT]                  = init_q;
    stat_word[STAT_ACPT_BIT]                  = acpt_q;
  end

  // read mux
  wire [31:0] rd_word = hit_ctrl ? {30'h0, ctrl_q} :
                        hit_rmbl ? {28'h0, rmbl_ovr_q} :
                        hit_used ? {28'h0, used_ovr_q} :
                        hit_stat ? stat_word : 32'h0000_0000;

  // apb answers in the access phase with no wait states
  assign pready  = 1'b1;
  assign pslverr = access_ph && !mapped;
  assign prdata  = prdata_q;

  // read data captured during the setup cycle
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup_ph) begin
      prdata_q <= pwrite ? 32'h0000_0000 : rd_word;
    end
  end

  // software-written configuration, standing in for eeprom or host writes
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl_q     <= CTRL_RST;
      rmbl_ovr_q <= OVR_RST;
      rmbl_set_q <= 1'b0;
      used_ovr_q <= OVR_RST;
      used_set_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= pwdata[1:0];
      end
      if (wr_rmbl) begin
        rmbl_ovr_q <= pwdata[3:0];
        rmbl_set_q <= 1'b1;
      end
      if (wr_used) begin
        used_ovr_q <= pwdata[3:0];
        used_set_q <= 1'b1;
      end
    end
  end

  // registered results; nothing is driven before straps are held
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      removable_q <= 4'h0;
      used_q      <= 4'h0;
      init_q      <= 1'b0;
      acpt_q      <= 1'b0;
    end else if (sif.captured) begin
      removable_q <= rmbl_eff;
      used_q      <= used_eff;
      init_q      <= init_eff;
      acpt_q      <= acpt_eff;
    end
  end

  assign port_removable   = removable_q;
  assign port_used        = used_q;
  assign u1u2_initiate_en = init_q;
  assign u1u2_accept_en   = acpt_q;

  // eeprom clock divider, only once the clock strap is held
  wire scl_run  = host_interface_mode_select && sif.captured;
  wire scl_tick = scl_run && (scl_cnt_q == CNT_W'(SCL_HALF - 1));

  always_ff @(posedge ref_clk) begin
    if (srst || !scl_run) begin
      scl_cnt_q   <= '0;
      scl_level_q <= 1'b1;
    end else if (scl_tick) begin
      scl_cnt_q   <= '0;
      scl_level_q <= !scl_level_q;
    end else begin
      scl_cnt_q   <= scl_cnt_q + CNT_W'(1);
    end
  end

  // open drain: pull low only, host drives the pin in the other mode
  assign scl_out = 1'b0;
  assign scl_oe  = scl_run && !scl_level_q;

  // clock level seen from the external host
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      smb_clk_q <= 1'b0;
    end else begin
      smb_clk_q <= host_interface_mode_select ? 1'b0 : shared_serial_clock_pin;
    end
  end

  assign smbus_clk_level = smb_clk_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  sequence s_rmbl_write;
    wr_rmbl;
  endsequence
  sequence s_rmbl_seen;
    ##2 port_removable == $past(pwdata[3:0], 2);
  endsequence
  property p_rmbl_ovr;
    s_rmbl_write ##0 sif.captured |-> s_rmbl_seen;
  endproperty
  a_rmbl_ovr: assert property (p_rmbl_ovr) else $error("removable write not applied");

  property p_used_ovr;
    wr_used && sif.captured |-> ##2 port_used == $past(pwdata[3:0], 2);
  endproperty
  a_used_ovr: assert property (p_used_ovr) else $error("port used write not applied");

  property p_scl_toggle;
    scl_tick |=> scl_level_q != $past(scl_level_q) && scl_cnt_q == '0;
  endproperty
  a_scl_toggle: assert property (p_scl_toggle) else $error("eeprom clock did not toggle");

  property p_host_clock;
    !host_interface_mode_select |-> !scl_oe;
  endproperty
  a_host_clock: assert property (p_host_clock) else $error("clock pin driven in host mode");

  property p_clk_strap;
    sif.captured && !cfg_loaded && !sif.sda_strap |=> u1u2_accept_en && u1u2_initiate_en == !$past(sif.scl_strap);
  endproperty
  a_clk_strap: assert property (p_clk_strap) else $error("clock strap policy wrong");

  property p_clk_high;
    sif.captured && !cfg_loaded && !sif.sda_strap && sif.scl_strap |=> !u1u2_initiate_en && u1u2_accept_en;
  endproperty
  a_clk_high: assert property (p_clk_high) else $error("initiation not blocked by clock strap");

  property p_data_prio;
    sif.captured && !cfg_loaded && sif.sda_strap |=> !u1u2_initiate_en && !u1u2_accept_en;
  endproperty
  a_data_prio: assert property (p_data_prio) else $error("data strap did not take priority");

  property p_loaded_bit;
    sif.captured && cfg_loaded |=> u1u2_initiate_en == !$past(lp_disable) && u1u2_accept_en == !$past(lp_disable);
  endproperty
  a_loaded_bit: assert property (p_loaded_bit) else $error("loaded disable bit ignored");

  property p_bad_addr;
    access_ph && !mapped |-> pslverr && pready;
  endproperty
  a_bad_addr: assert property (p_bad_addr) else $error("unmapped access not flagged");

  // host mode: the clock level output follows the pin one cycle later
  property p_host_level;
    !srst && !host_interface_mode_select |=> smbus_clk_level == $past(shared_serial_clock_pin);
  endproperty
  a_host_level: assert property (p_host_level) else $error("host clock level not followed");

  // with nothing loaded or written, the held straps reach the outputs
  property p_strap_path;
    sif.captured && !cfg_loaded && !rmbl_set_q && !used_set_q |=>
      port_removable == $past(rmbl_strap) && port_used == $past(sif.used);
  endproperty
  a_strap_path: assert property (p_strap_path) else $error("strap values not passed on");

  // nothing is driven until the straps are held
  property p_idle_outputs;
    !sif.captured |=> port_removable == 4'h0 && port_used == 4'h0 && !u1u2_initiate_en && !u1u2_accept_en;
  endproperty
  a_idle_outputs: assert property (p_idle_outputs) else $error("outputs driven before capture");

  // a write to an unmapped address leaves every register alone
  property p_unmapped_wr;
    access_ph && pwrite && !mapped |=> $stable(ctrl_q) && $stable(rmbl_ovr_q) && $stable(used_ovr_q);
  endproperty
  a_unmapped_wr: assert property (p_unmapped_wr) else $error("unmapped write changed a register");

  // the eeprom clock starts in its high half, pin released
  property p_scl_start;
    $rose(scl_run) |-> scl_level_q && !scl_oe;
  endproperty
  a_scl_start: assert property (p_scl_start) else $error("eeprom clock did not start high");

  // the half-period counter never runs past its end point
  property p_cnt_bound;
    scl_cnt_q < CNT_W'(SCL_HALF);
  endproperty
  a_cnt_bound: assert property (p_cnt_bound) else $error("eeprom clock counter out of range");

  // loaded configuration wins over a captured data strap
  property p_loaded_over_strap;
    sif.captured && cfg_loaded && !lp_disable && sif.sda_strap |=> u1u2_initiate_en && u1u2_accept_en;
  endproperty
  a_loaded_over_strap: assert property (p_loaded_over_strap) else $error("straps beat loaded config");
endmodule

// >>> test/hsc_serial_partner.sv
`timescale 1ns/1ps
// far side of the shared serial clock pin: eeprom bus or external smbus host
module hsc_serial_partner (
  input  wire logic ref_clk,
  input  wire logic mode,
  input  wire logic strap_hold,
  input  wire logic strap_lvl,
  input  wire logic host_run,
  input  wire logic scl_oe,
  output logic      pin
);
  logic [1:0] div_q = 2'h0;
  logic       host_q = 1'b0;

  // host clock toggles every third cycle inside a frame, stands still outside
  always_ff @(posedge ref_clk) begin
    if (host_run) begin
      div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
      host_q <= (div_q == 2'h2) ? ~host_q : host_q;
    end
  end

  // pull-low wins, strap resistor during reset, host drives in smbus mode
  assign pin = scl_oe ? 1'b0 : (strap_hold ? strap_lvl : (mode ? 1'b1 : host_q));
endmodule

// >>> test/tb_hsc_strap_config_sampler.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module tb_hsc_strap_config_sampler;
  import hsc_pkg::*;
  localparam int HALF = 4;
  logic        ref_clk, srst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic        amber, mode, sda, scl_pin, scl_out, scl_oe, clk_lvl, init_en, acc_en, p;
  logic [3:0]  green, rmbl, used;
  logic        strap_hold, strap_scl, host_run;
  logic [9:0]  exp_st;
  logic [11:0] look_q[$], e_l;
  logic [32:0] rd_q[$], e_r;
  int          fail_count, num_checks, n;
  event        look_ev;

  hsc_strap_config_sampler #(.SCL_HALF(HALF)) i_dut (
    .ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port3_amber_removable_strap(amber), .port0_green_used_strap(green[0]),
    .port1_green_used_strap(green[1]), .port2_green_used_strap(green[2]),
    .port3_green_used_strap(green[3]), .host_interface_mode_select(mode),
    .shared_serial_clock_pin(scl_pin), .scl_out(scl_out), .scl_oe(scl_oe),
    .shared_serial_data_pin(sda), .smbus_clk_level(clk_lvl), .port_removable(rmbl),
    .port_used(used), .u1u2_initiate_en(init_en), .u1u2_accept_en(acc_en)
  );

  hsc_serial_partner i_far (
    .ref_clk(ref_clk), .mode(mode), .strap_hold(strap_hold), .strap_lvl(strap_scl),
    .host_run(host_run), .scl_oe(scl_oe), .pin(scl_pin)
  );

  // free-running bench clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // low-power policy {initiate, accept} expected from the two straps
  function automatic logic [1:0] pol(input logic s_scl, input logic s_sda);
    return s_sda ? 2'b00 : (s_scl ? 2'b01 : 2'b11);
  endfunction

  // one apb transfer, entered and left just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  // note the expected output vector and let the monitor compare it
  task automatic look(input logic oe, input logic lvl);
    look_q.push_back({oe, lvl, exp_st});
    -> look_ev;
  endtask

  // reset with given strap levels, then disturb the pins after capture
  task automatic do_reset(input logic amb, input logic [3:0] grn, input logic s_scl, input logic s_sda);
    amber <= amb;
    green <= grn;
    strap_scl <= s_scl;
    sda <= s_sda;
    strap_hold <= 1'b1;
    srst <= 1'b1;
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    strap_hold <= 1'b0;
    amber <= ~amb;
    green <= ~grn;
    sda <= ~s_sda;
    exp_st = {pol(s_scl, s_sda), grn, amb, RMBL_LOW_STRAP};
    repeat (3) @(posedge ref_clk);
  endtask

  // output monitor: oldest note against the settled outputs
  always @(look_ev) begin
    e_l = look_q.pop_front();
    `CHK({scl_oe, clk_lvl, init_en, acc_en, used, rmbl}, e_l)
  end

  // read monitor: compares each completed read with the oldest note
  always @(posedge ref_clk) begin
    if (psel && penable && pready && !pwrite) begin
      e_r = rd_q.pop_front();
      `CHK({pslverr, prdata}, e_r)
    end
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // watchdog sized well above the roughly 120 cycles the tests need
  initial begin
    #(20 * 20000);
    fail_count++;
    summarize();
  end

  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {amber, green, mode, sda, strap_scl, host_run} = '0;
    strap_hold = 1'b1;
    srst = 1'b1;
    exp_st = '0;
    fail_count = 0;
    num_checks = 0;
    void'($urandom(4091));
    @(posedge ref_clk);
    for (int i = 0; i < 4; i++) begin
      r = $urandom;
      do_reset(r[0], r[4:1], i[0], i[1]);
      @(negedge ref_clk);
      look(1'b0, 1'b0);
      @(posedge ref_clk);
      rd_q.push_back({19'h0, exp_st[8], exp_st[9], mode, i[1], i[0], 1'b1, exp_st[7:0]});
      apb(1'b0, STAT_ADDR, 32'h0);
      $display("strap set %0d done", i);
    end
    r = $urandom;
    apb(1'b1, RMBL_ADDR, {28'h0, r[3:0]});
    apb(1'b1, USED_ADDR, {28'h0, r[7:4]});
    apb(1'b1, 8'h10, 32'hFFFFFFFF);
    exp_st[7:0] = {r[7:4], r[3:0]};
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    look(1'b0, 1'b0);
    $display("override test done");
    @(posedge ref_clk);
    apb(1'b1, CTRL_ADDR, 32'h1);
    exp_st[9:8] = 2'b11;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    look(1'b0, 1'b0);
    @(posedge ref_clk);
    apb(1'b1, CTRL_ADDR, 32'h3);
    exp_st[9:8] = 2'b00;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    look(1'b0, 1'b0);
    @(posedge ref_clk);
    rd_q.push_back({1'b0, 32'h3});
    apb(1'b0, CTRL_ADDR, 32'h0);
    rd_q.push_back({1'b1, 32'h0});
    apb(1'b0, 8'h10, 32'h0);
    $display("config test done");
    mode <= 1'b1;
    n = 0;
    @(negedge ref_clk);
    while (scl_oe !== 1'b1) @(negedge ref_clk);
    while (scl_oe === 1'b1) begin
      n++;
      `CHK({scl_out, scl_pin}, 2'b00)
      @(negedge ref_clk);
    end
    `CHK(n, HALF)
    @(negedge ref_clk);
    look(1'b0, 1'b0);
    $display("eeprom clock test done");
    @(posedge ref_clk);
    mode <= 1'b0;
    host_run <= 1'b1;
    repeat (3) @(posedge ref_clk);
    for (int k = 0; k < 8; k++) begin
      @(negedge ref_clk);
      p = scl_pin;
      @(negedge ref_clk);
      look(1'b0, p);
    end
    @(posedge ref_clk);
    host_run <= 1'b0;
    $display("host clock test done");
    repeat (2) @(posedge ref_clk);
    summarize();
  end
endmodule
